// ### core/device_identification_regs.sv
`timescale 1ns/1ps

// Contract
// R1 - Read-only identification code word at its address.
// R2 - Bit 31 reads one: coprocessor present.
// R3 - Bits 30:17 hold the die configuration number.
// R4 - Bits 16:13 hold the process code.
// R5 - Bit 12 zero means 3.3 V I/O.
// R6 - Bit 11 one: peripheral memory parity.
// R7 - Bits 10:9 read 10b: program memory ECC.
// R8 - Bit 8 one: RAM has ECC.
// R9 - Bits 7:3 hold the silicon revision.
// R10 - Bits 2:0 hold fixed platform family code.
// R11 - Two read-only words form the die identifier.
// R12 - Low: X, Y, wafer; high: lot, reserved.
// R13 - Writes never change identification or die values.
module device_identification_regs #(
  parameter logic [13:0] CFG_NUMBER   = 14'h0123, // Arbitrary value.
  parameter logic [3:0]  PROCESS_CODE = 4'h3,     // Arbitrary value.
  parameter logic [4:0]  REVISION     = 5'h00,    // Arbitrary value.
  parameter logic [2:0]  FAMILY_CODE  = 3'h3      // Arbitrary value.
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [27:0] adr_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic             ack_o,
  output logic             err_o,
  input  wire logic [11:0] die_x_i,
  input  wire logic [11:0] die_y_i,
  input  wire logic [7:0]  wafer_i,
  input  wire logic [23:0] lot_i
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------

  // Word match; the two low byte-address bits never select anything.
  function automatic logic addr_hit(input logic [27:0] a,
                                    input logic [27:0] ofs);
    addr_hit = (a[27:2] == ofs[27:2]);
  endfunction : addr_hit

  logic [31:0] part_word;
  logic [55:0] fuse_bits;
  logic [31:0] die_low;
  logic [31:0] die_high;
  logic        strict;
  logic        die_valid;
  logic        pending;
  logic [1:0]  settle;
  logic [7:0]  wr_cnt;

  wire req      = cyc_i & stb_i & ~ack_o & ~err_o;
  wire hit_part = addr_hit(adr_i, id_regs_pkg::PART_ID_OFS);
  wire hit_low  = addr_hit(adr_i, id_regs_pkg::DIE_LOW_OFS);
  wire hit_high = addr_hit(adr_i, id_regs_pkg::DIE_HIGH_OFS);
  wire hit_ctrl = addr_hit(adr_i, id_regs_pkg::CTRL_OFS);
  wire hit_stat = addr_hit(adr_i, id_regs_pkg::STAT_OFS);
  wire hit_ro   = hit_part | hit_low | hit_high | hit_stat;
  wire hit_any  = hit_ro | hit_ctrl;

  // A write to a read-only word is dropped; strict mode also flags it.
  wire ro_write  = req & we_i & hit_ro; // R13
  wire next_err  = req & (~hit_any | (ro_write & strict));
  wire next_ack  = req & ~next_err;
  wire ctrl_wr   = next_ack & we_i & hit_ctrl & sel_i[0];
  wire recapture = ctrl_wr & dat_i[id_regs_pkg::CTRL_RECAP_BIT];

  // ----------------------------------------------------------------
  // Fixed identification word and fuse pins
  // ----------------------------------------------------------------

  part_id_word #(
    .CFG_NUMBER  (CFG_NUMBER),
    .PROCESS_CODE(PROCESS_CODE),
    .REVISION    (REVISION),
    .FAMILY_CODE (FAMILY_CODE)
  ) u_word (
    .word_o(part_word)
  );

  // Fuses are static, but still arrive from outside this clock domain.
  fuse_sync #(
    .WIDTH(56)
  ) u_sync (
    .clk_i (clk_i),
    .pins_i({lot_i, wafer_i, die_y_i, die_x_i}),
    .sync_o(fuse_bits)
  );

  wire [11:0] sx   = fuse_bits[11:0];
  wire [11:0] sy   = fuse_bits[23:12];
  wire [7:0]  swaf = fuse_bits[31:24];
  wire [23:0] slot = fuse_bits[55:32];

  // ----------------------------------------------------------------
  // Die identifier capture
  // ----------------------------------------------------------------

  // Capture waits for the synchroniser to fill after reset or a
  // recapture; before then a read returns zero after reset, the previous capture after a recapture.
  wire capture = pending & (settle == 2'h0);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pending <= 1'b1;
      settle  <= id_regs_pkg::SETTLE_CYCLES;
    end else if (recapture) begin
      pending <= 1'b1;
      settle  <= id_regs_pkg::SETTLE_CYCLES;
    end else if (capture) begin
      pending <= 1'b0;
    end else if (pending) begin
      settle <= settle - 2'h1;
    end
  end

  // Only a capture may load the die words; bus writes never reach them.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      die_low   <= '0;
      die_high  <= '0;
      die_valid <= 1'b0;
    end else if (recapture) begin
      die_valid <= 1'b0;
    end else if (capture) begin
      die_low[id_regs_pkg::XC_MSB:id_regs_pkg::XC_LSB] <= sx; // R12
      die_low[id_regs_pkg::YC_MSB:id_regs_pkg::YC_LSB] <= sy;
      die_low[id_regs_pkg::WAFER_MSB:id_regs_pkg::WAFER_LSB] <= swaf;
      die_high[id_regs_pkg::LOT_MSB:id_regs_pkg::LOT_LSB] <= slot;
      die_high[31:24] <= id_regs_pkg::DIE_RSVD_VAL;
      die_valid <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Control and status
  // ----------------------------------------------------------------

  // Strict mode turns writes to read-only words into bus errors.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strict <= id_regs_pkg::STRICT_RESET;
    end else if (ctrl_wr) begin
      strict <= dat_i[id_regs_pkg::CTRL_STRICT_BIT];
    end
  end

  // Counts dropped writes, saturating so the count never wraps to zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_cnt <= id_regs_pkg::WCNT_RESET;
    end else if (ro_write && wr_cnt != id_regs_pkg::WCNT_MAX) begin
      wr_cnt <= wr_cnt + 8'h01; // R13
    end
  end

  // ----------------------------------------------------------------
  // Read mux and bus answer
  // ----------------------------------------------------------------

  wire [31:0] ctrl_word = {30'h0, strict, 1'b0};
  wire [31:0] stat_word = {16'h0, wr_cnt, 7'h0, die_valid};

  wire [31:0] next_dat =
    hit_part ? part_word : // R1
    hit_low  ? die_low   : // R11
    hit_high ? die_high  :
    hit_ctrl ? ctrl_word :
    hit_stat ? stat_word : 32'h0;

  // One wait cycle, then a single-cycle ack or err; read data comes only with ack.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= '0;
    end else begin
      ack_o <= next_ack;
      err_o <= next_err;
      if (next_ack && !we_i) begin
        dat_o <= next_dat;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  a_part_read: assert property ( // R1
    @(posedge clk_i) disable iff (rst_i)
    req && !we_i && hit_part |=> ack_o && dat_o == part_word)
  else $error("identification word read wrong");

  a_coproc_flag: assert property ( // R2
    @(posedge clk_i) disable iff (rst_i)
    ack_o && $past(hit_part && !we_i) |-> dat_o[31] == 1'b1)
  else $error("coprocessor flag not set");

  a_cfg_field: assert property ( // R3
    @(posedge clk_i) disable iff (rst_i)
    part_word[30:17] == CFG_NUMBER)
  else $error("configuration number wrong");

  a_process_field: assert property ( // R4
    @(posedge clk_i) disable iff (rst_i)
    part_word[16:13] == PROCESS_CODE)
  else $error("process code wrong");

  a_io_level: assert property ( // R5
    @(posedge clk_i) disable iff (rst_i)
    part_word[12] == 1'b0)
  else $error("I/O level bit wrong");

  a_parity_flag: assert property ( // R6
    @(posedge clk_i) disable iff (rst_i)
    part_word[11] == 1'b1)
  else $error("parity flag wrong");

  a_pmem_ecc: assert property ( // R7
    @(posedge clk_i) disable iff (rst_i)
    part_word[10:9] == 2'h2)
  else $error("program memory ECC field wrong");

  a_ram_ecc: assert property ( // R8
    @(posedge clk_i) disable iff (rst_i)
    part_word[8] == 1'b1)
  else $error("RAM ECC flag wrong");

  a_rev_field: assert property ( // R9
    @(posedge clk_i) disable iff (rst_i)
    part_word[7:3] == REVISION)
  else $error("revision field wrong");

  a_family_code: assert property ( // R10
    @(posedge clk_i) disable iff (rst_i)
    part_word[2:0] == FAMILY_CODE)
  else $error("family code wrong");

  a_die_read: assert property ( // R11
    @(posedge clk_i) disable iff (rst_i)
    req && !we_i && hit_high && !capture |=> ack_o && dat_o == die_high)
  else $error("die identifier read wrong");

  a_die_layout: assert property ( // R12
    @(posedge clk_i) disable iff (rst_i)
    capture && !recapture |=>
      die_low == {$past(swaf), $past(sy), $past(sx)} &&
      die_high == {8'h00, $past(slot)})
  else $error("die identifier layout wrong");

  a_write_ignored: assert property ( // R13
    @(posedge clk_i) disable iff (rst_i)
    ro_write && !capture |=> $stable(die_low) && $stable(die_high))
  else $error("write altered a read-only word");

  a_ack_single: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o && !err_o)
  else $error("ack held longer than one cycle");

  a_unmapped_err: assert property (
    @(posedge clk_i) disable iff (rst_i)
    req && !hit_any |=> err_o && !ack_o)
  else $error("unmapped access not answered with err");

  a_capture_delay: assert property (
    @(posedge clk_i) disable iff (rst_i)
    recapture |=> !die_valid [*3])
  else $error("recapture settled too early");

  // ----------------------------------------------------------------
  // Bus answer and register behaviour checks
  // ----------------------------------------------------------------

  // A master that saw ack and err together could not tell the outcome.
  a_ack_err_excl: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !(ack_o && err_o))
  else $error("ack and err raised together");

  a_err_single: assert property (
    @(posedge clk_i) disable iff (rst_i)
    err_o |=> !ack_o && !err_o)
  else $error("err held longer than one cycle");

  a_idle_quiet: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !(cyc_i && stb_i) |=> !ack_o && !err_o)
  else $error("answer without a request");

  a_part_word_read: assert property ( // R1
    @(posedge clk_i) disable iff (rst_i)
    ack_o && $past(hit_part && !we_i) |->
      dat_o == {id_regs_pkg::COPROC_VAL, CFG_NUMBER, PROCESS_CODE,
                id_regs_pkg::IO_3V3_VAL, id_regs_pkg::PARITY_VAL,
                id_regs_pkg::PMEM_ECC_VAL, id_regs_pkg::RAM_ECC_VAL,
                REVISION, FAMILY_CODE})
  else $error("identification word fields wrong");

  a_low_read: assert property ( // R11
    @(posedge clk_i) disable iff (rst_i)
    req && !we_i && hit_low && !capture |=> ack_o && dat_o == die_low)
  else $error("die identifier low read wrong");

  // Status is sampled at the taking edge; a capture may move it just after.
  a_stat_read: assert property (
    @(posedge clk_i) disable iff (rst_i)
    req && !we_i && hit_stat |=>
      ack_o && dat_o[31:16] == 16'h0 && dat_o[7:1] == 7'h0 &&
      dat_o[id_regs_pkg::STAT_CNT_MSB:id_regs_pkg::STAT_CNT_LSB] ==
        $past(wr_cnt) &&
      dat_o[id_regs_pkg::STAT_VALID_BIT] == $past(die_valid))
  else $error("status read wrong");

  a_ctrl_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ctrl_wr |=> strict == $past(dat_i[id_regs_pkg::CTRL_STRICT_BIT]))
  else $error("strict bit not written");

  a_strict_err: assert property ( // R13
    @(posedge clk_i) disable iff (rst_i)
    req && we_i && hit_ro && strict |=> err_o && !ack_o)
  else $error("strict read-only write not refused");

  a_lax_ack: assert property ( // R13
    @(posedge clk_i) disable iff (rst_i)
    req && we_i && hit_ro && !strict |=> ack_o && !err_o)
  else $error("read-only write not acknowledged");

  a_write_dat_hold: assert property ( // R13
    @(posedge clk_i) disable iff (rst_i)
    req && we_i |=> $stable(dat_o))
  else $error("write changed read data");

  // The drop count steps once per dropped word and stops at its top.
  a_cnt_step: assert property ( // R13
    @(posedge clk_i) disable iff (rst_i)
    ro_write && wr_cnt != id_regs_pkg::WCNT_MAX |=>
      wr_cnt == $past(wr_cnt) + 8'h01)
  else $error("drop count did not step");

  a_cnt_sat: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_cnt == id_regs_pkg::WCNT_MAX |=> wr_cnt == id_regs_pkg::WCNT_MAX)
  else $error("drop count wrapped");

  a_cnt_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !ro_write |=> $stable(wr_cnt))
  else $error("drop count moved without a write");

endmodule : device_identification_regs

// ### core/fuse_sync.sv
`timescale 1ns/1ps

// Two-stage synchroniser for the static die fuse pins.
module fuse_sync #(
  parameter int WIDTH = 56
) (
  input  wire logic             clk_i,
  input  wire logic [WIDTH-1:0] pins_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1;

  // The first stage feeds only the second; nothing else looks at it.
  always_ff @(posedge clk_i) begin
    stage1 <= pins_i;
    sync_o <= stage1;
  end

endmodule : fuse_sync

// ### core/id_regs_pkg.sv
package id_regs_pkg;

  // ----------------------------------------------------------------
  // Bus geometry and register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W       = 28;
  localparam int          DATA_W       = 32;
  localparam logic [27:0] DIE_LOW_OFS  = 28'hfffff7c;
  localparam logic [27:0] DIE_HIGH_OFS = 28'hfffff80;
  localparam logic [27:0] PART_ID_OFS  = 28'hffffff0;
  localparam logic [27:0] CTRL_OFS     = 28'hffffff4;
  localparam logic [27:0] STAT_OFS     = 28'hffffff8;

  // ----------------------------------------------------------------
  // Identification code word layout and fixed field values
  // ----------------------------------------------------------------
  localparam int         COPROC_BIT   = 31;
  localparam int         CFG_MSB      = 30;
  localparam int         CFG_LSB      = 17;
  localparam int         PROC_MSB     = 16;
  localparam int         PROC_LSB     = 13;
  localparam int         IO_BIT       = 12;
  localparam int         PARITY_BIT   = 11;
  localparam int         PMEM_MSB     = 10;
  localparam int         PMEM_LSB     = 9;
  localparam int         RAM_BIT      = 8;
  localparam int         REV_MSB      = 7;
  localparam int         REV_LSB      = 3;
  localparam int         FAM_MSB      = 2;
  localparam int         FAM_LSB      = 0;
  localparam logic       COPROC_VAL   = 1'b1;
  localparam logic       IO_3V3_VAL   = 1'b0;
  localparam logic       PARITY_VAL   = 1'b1;
  localparam logic [1:0] PMEM_ECC_VAL = 2'h2;
  localparam logic       RAM_ECC_VAL  = 1'b1;

  // ----------------------------------------------------------------
  // Die identifier layout
  // ----------------------------------------------------------------
  localparam int       XC_MSB    = 11;
  localparam int       XC_LSB    = 0;
  localparam int       YC_MSB    = 23;
  localparam int       YC_LSB    = 12;
  localparam int       WAFER_MSB = 31;
  localparam int       WAFER_LSB = 24;
  localparam int       LOT_MSB   = 23;
  localparam int       LOT_LSB   = 0;
  localparam logic [7:0] DIE_RSVD_VAL = 8'h00;

  // ----------------------------------------------------------------
  // Control and status fields, reset values, timing
  // ----------------------------------------------------------------
  localparam int         CTRL_RECAP_BIT  = 0;
  localparam int         CTRL_STRICT_BIT = 1;
  localparam logic       STRICT_RESET    = 1'b0;
  localparam int         STAT_VALID_BIT  = 0;
  localparam int         STAT_CNT_LSB    = 8;
  localparam int         STAT_CNT_MSB    = 15;
  localparam logic [7:0] WCNT_RESET      = 8'h00;
  localparam logic [7:0] WCNT_MAX        = 8'hff;
  localparam logic [1:0] SETTLE_CYCLES   = 2'h2;

endpackage : id_regs_pkg

// ### core/part_id_word.sv
`timescale 1ns/1ps

// Builds the fixed identification code word from its field values.
module part_id_word #(
  parameter logic [13:0] CFG_NUMBER   = 14'h0123, // Arbitrary value.
  parameter logic [3:0]  PROCESS_CODE = 4'h3,     // Arbitrary value.
  parameter logic [4:0]  REVISION     = 5'h00,    // Arbitrary value.
  parameter logic [2:0]  FAMILY_CODE  = 3'h3      // Arbitrary value.
) (
  output logic [31:0] word_o
);

  // Every field is a constant, so this collapses to tie-offs.
  always_comb begin
    word_o = '0;
    word_o[id_regs_pkg::COPROC_BIT] = id_regs_pkg::COPROC_VAL; // R2
    word_o[id_regs_pkg::CFG_MSB:id_regs_pkg::CFG_LSB] = CFG_NUMBER; // R3
    word_o[id_regs_pkg::PROC_MSB:id_regs_pkg::PROC_LSB] =
      PROCESS_CODE; // R4
    word_o[id_regs_pkg::IO_BIT] = id_regs_pkg::IO_3V3_VAL; // R5
    word_o[id_regs_pkg::PARITY_BIT] = id_regs_pkg::PARITY_VAL; // R6
    word_o[id_regs_pkg::PMEM_MSB:id_regs_pkg::PMEM_LSB] =
      id_regs_pkg::PMEM_ECC_VAL; // R7
    word_o[id_regs_pkg::RAM_BIT] = id_regs_pkg::RAM_ECC_VAL; // R8
    word_o[id_regs_pkg::REV_MSB:id_regs_pkg::REV_LSB] = REVISION; // R9
    word_o[id_regs_pkg::FAM_MSB:id_regs_pkg::FAM_LSB] =
      FAMILY_CODE; // R10
  end

endmodule : part_id_word

// ### verif/device_identification_regs_test.sv
`timescale 1ns/1ps

module device_identification_regs_test;

  // ----------------------------------------------------------------
  // Bench parameters, stimulus signals and counters
  // ----------------------------------------------------------------
  localparam logic [13:0] CFG  = 14'h1a5c; // Arbitrary value.
  localparam logic [3:0]  PROC = 4'h9;     // Arbitrary value.
  localparam logic [4:0]  REV  = 5'h0b;    // Arbitrary value.
  localparam logic [2:0]  FAM  = 3'h6;     // Arbitrary value.

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [27:0] adr_i = '0;
  logic [31:0] dat_i = '0;
  logic [31:0] dat_o;
  logic        we_i  = 1'b0;
  logic [3:0]  sel_i = 4'h0;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        ack_o;
  logic        err_o;
  logic [11:0] die_x_i = 12'habc;
  logic [11:0] die_y_i = 12'h123;
  logic [7:0]  wafer_i = 8'h5e;
  logic [23:0] lot_i   = 24'h9a7b3c;
  int          err_count   = 0;
  int          check_count = 0;
  logic [31:0] q;
  logic        e;
  logic [31:0] id_exp;

  assign id_exp = {id_regs_pkg::COPROC_VAL, CFG, PROC, id_regs_pkg::IO_3V3_VAL,
                   id_regs_pkg::PARITY_VAL, id_regs_pkg::PMEM_ECC_VAL,
                   id_regs_pkg::RAM_ECC_VAL, REV, FAM};

  // Clock at 40 MHz.
  always #12.5 clk_i = ~clk_i;

  device_identification_regs #(
    .CFG_NUMBER   (CFG),
    .PROCESS_CODE (PROC),
    .REVISION     (REV),
    .FAMILY_CODE  (FAM)
  ) dut (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .adr_i   (adr_i),
    .dat_i   (dat_i),
    .dat_o   (dat_o),
    .we_i    (we_i),
    .sel_i   (sel_i),
    .cyc_i   (cyc_i),
    .stb_i   (stb_i),
    .ack_o   (ack_o),
    .err_o   (err_o),
    .die_x_i (die_x_i),
    .die_y_i (die_y_i),
    .wafer_i (wafer_i),
    .lot_i   (lot_i)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // One classic cycle; the answer is awaited, never assumed.
  task automatic wb(input logic w, input logic [27:0] a,
                    input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1 && err_o !== 1'b1);
    q = dat_o;
    e = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  // Polls the valid flag; the capture needs a few edges after a trigger.
  task automatic wait_valid();
    int n;
    n = 0;
    do begin
      wb(1'b0, id_regs_pkg::STAT_OFS, '0);
      n++;
    end while (q[0] !== 1'b1 && n < 10);
    chk("die valid", {31'h0, q[0]}, 32'h1);
  endtask : wait_valid

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_part_id();
    wb(1'b0, id_regs_pkg::PART_ID_OFS, '0);
    chk("part id err", {31'h0, e}, 32'h0);
    chk("part id", q, id_exp);
    $display("test part id done");
  endtask : t_part_id

  task automatic t_die(input logic [63:0] exp);
    wait_valid();
    wb(1'b0, id_regs_pkg::DIE_LOW_OFS, '0);
    chk("die low", q, exp[31:0]);
    wb(1'b0, id_regs_pkg::DIE_HIGH_OFS, '0);
    chk("die high", q, exp[63:32]);
    $display("test die_identifier_high done");
  endtask : t_die

  // Writes to read-only words are dropped and counted; in strict mode they also get err.
  task automatic t_ro_writes();
    wb(1'b1, id_regs_pkg::PART_ID_OFS, 32'h0);
    chk("ro write err", {31'h0, e}, 32'h0);
    wb(1'b1, id_regs_pkg::DIE_LOW_OFS, 32'hffffffff);
    wb(1'b1, id_regs_pkg::DIE_HIGH_OFS, 32'hffffffff);
    wb(1'b0, id_regs_pkg::STAT_OFS, '0);
    chk("drop count", {24'h0, q[15:8]}, 32'h3);
    wb(1'b1, id_regs_pkg::CTRL_OFS, 32'h2);
    wb(1'b1, id_regs_pkg::PART_ID_OFS, 32'h0);
    chk("strict err", {31'h0, e}, 32'h1);
    wb(1'b1, id_regs_pkg::CTRL_OFS, 32'h0);
    wb(1'b0, id_regs_pkg::PART_ID_OFS, '0);
    chk("part id after", q, id_exp);
    wb(1'b0, id_regs_pkg::DIE_LOW_OFS, '0);
    chk("die low after", q, {8'h5e, 12'h123, 12'habc});
    wb(1'b0, id_regs_pkg::DIE_HIGH_OFS, '0);
    chk("die high after", q, {8'h00, 24'h9a7b3c});
    $display("test ro writes done");
  endtask : t_ro_writes

  task automatic t_unmapped();
    wb(1'b0, 28'h0000000, '0);
    chk("unmapped err", {31'h0, e}, 32'h1);
    wb(1'b0, 28'hffffffc, '0);
    chk("unmapped err top", {31'h0, e}, 32'h1);
    $display("test unmapped done");
  endtask : t_unmapped

  // New fuse levels are seen only after a recapture.
  task automatic t_recapture();
    die_x_i <= 12'h5a1;
    die_y_i <= 12'hfe0;
    wafer_i <= 8'h07;
    lot_i   <= 24'h00c0de;
    wb(1'b1, id_regs_pkg::CTRL_OFS, 32'h1);
    t_die({8'h00, 24'h00c0de, 8'h07, 12'hfe0, 12'h5a1});
    $display("test recapture done");
  endtask : t_recapture

  // ----------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // The tests need well under a thousand cycles; this allows ample slack.
  initial begin
    #(25 * 5000);
    err_count++;
    report_and_stop();
  end

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_part_id();
    t_die({8'h00, 24'h9a7b3c, 8'h5e, 12'h123, 12'habc});
    t_ro_writes();
    t_unmapped();
    t_recapture();
    report_and_stop();
  end

endmodule : device_identification_regs_test
